// file: rtl/lgc_cell.sv
// Top of the configurable logic cell: registers, selectors and gates.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module lgc_cell
    import lgc_pkg::*;
#(
    parameter int CLK_IDX = 0,
    parameter int D_IDX = 1,
    parameter int RST_IDX = 2,
    parameter int D2_IDX = 3,
    parameter int SET_IDX = 3
) (
    input wire logic CLK_SYS,
    input wire logic SRST,
    // Register port
    input wire logic [LGC_ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Pins, asynchronous to the system clock
    input wire logic PIN_IN_A,
    input wire logic PIN_IN_B,
    // On-chip sources for selectors 1 and 2, codes 1 to 7
    input wire logic [7:1] SEL1_SRC,
    input wire logic [7:1] SEL2_SRC,
    // Selector 3 sources
    input wire logic CMP2_OUT,
    input wire logic SPI_SDO,
    input wire logic UART_RX,
    input wire logic CAPTURE2_OUTPUT,
    input wire logic CAPTURE2_MATCH,
    input wire logic CAPTURE3_MATCH,
    // Selector 4 sources
    input wire logic SIBLING_OUT,
    input wire logic CAPTURE3_OUTPUT,
    input wire logic SPI_SDI,
    input wire logic CLOCK_CALENDAR_EVENT,
    input wire logic MULTI_CAPTURE1_MATCH,
    // Outputs
    output logic CELL_OUT,
    output logic PIN_OUT,
    output logic PIN_OUTPUT_ENABLE,
    output logic IRQ
);

    // ************************************************************
    // Declarations
    // ************************************************************
    lgc_state_t st_reg;        // All registered state except that of the function stage
    lgc_state_t st_next;       // Its next value
    logic [7:0] src1;          // Selector 1 candidates
    logic [7:0] src2;          // Selector 2 candidates
    logic [7:0] src3;          // Selector 3 candidates
    logic [7:0] src4;          // Selector 4 candidates
    logic [3:0] sel_out;       // True selector outputs
    logic [7:0] pair;          // True and inverted selector outputs
    logic [3:0] gate_raw;      // Gate outputs before polarity
    logic [3:0] gate;          // Gate outputs after polarity
    logic fn_out;              // Logic function result
    logic cell_on;             // Cell enable
    logic [1:0] op;            // Alias operation of this access
    logic [7:0] base;          // Register base of this access

    // Apply a plain write or a clear, set or invert alias
    function automatic logic [31:0] lgc_apply(
        input logic [31:0] old,
        input logic [31:0] wd,
        input logic [1:0] kind,
        input logic [31:0] wmask
    );
        logic [31:0] val;
        val = old;
        case (kind)
            LGC_OP_CLR: val = old & ~wd;
            LGC_OP_SET: val = old | wd;
            LGC_OP_INV: val = old ^ wd;
            default: val = wd;
        endcase
        // Unimplemented bits never store
        return val & wmask;
    endfunction

    // Pick one selector code from the select register
    function automatic logic [2:0] lgc_code(
        input logic [31:0] sel,
        input int lsb
    );
        return sel[lsb +: 3];
    endfunction

    // ************************************************************
    // Selectors and gates
    // ************************************************************
    assign cell_on = st_reg.con[LGC_ON_BIT];
    assign src1 = {SEL1_SRC, st_reg.pin_a};
    assign src2 = {SEL2_SRC, st_reg.pin_b};
    // Own output comes from the status flop, so no combinational loop
    assign src3 = {CAPTURE3_MATCH, CAPTURE2_MATCH, CAPTURE2_OUTPUT,
                   UART_RX, SPI_SDO, CMP2_OUT, st_reg.out,
                   st_reg.pin_a};
    // Code 100 is reserved and reads as a constant low
    assign src4 = {CAPTURE3_MATCH, MULTI_CAPTURE1_MATCH,
                   CLOCK_CALENDAR_EVENT, 1'b0, SPI_SDI,
                   CAPTURE3_OUTPUT, SIBLING_OUT,
                   st_reg.pin_b};

    assign sel_out[0] = src1[lgc_code(st_reg.sel, LGC_SEL1_LSB)];
    assign sel_out[1] = src2[lgc_code(st_reg.sel, LGC_SEL2_LSB)];
    assign sel_out[2] = src3[lgc_code(st_reg.sel, LGC_SEL3_LSB)];
    assign sel_out[3] = src4[lgc_code(st_reg.sel, LGC_SEL4_LSB)];

    // Even bit is the inverted copy, odd bit the true one
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pair
            assign pair[2*gi] = ~sel_out[gi];
            assign pair[2*gi+1] = sel_out[gi];
        end
        for (gi = 0; gi < 4; gi++) begin : g_gate
            assign gate_raw[gi] = |(st_reg.gls[gi*LGC_GATE_FIELD_W +:
                LGC_GATE_FIELD_W] & pair);
            assign gate[gi] = gate_raw[gi] ^
                st_reg.con[LGC_GPOL_LSB + gi];
        end
    endgenerate

    // ************************************************************
    // Logic function
    // ************************************************************
    lgc_fn #(
        .CLK_IDX(CLK_IDX),
        .D_IDX(D_IDX),
        .RST_IDX(RST_IDX),
        .D2_IDX(D2_IDX),
        .SET_IDX(SET_IDX)
    ) u_fn (
        .clk(CLK_SYS),
        .srst(SRST),
        .enable(cell_on),
        .mode(st_reg.con[LGC_MODE_LSB +: 3]),
        .gate(gate),
        .fn_out(fn_out)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    assign op = ADDR[3:2];
    assign base = ADDR & LGC_BASE_MASK;

    // Registers, synchronisers, output and interrupt pulse
    always_comb begin
        st_next = st_reg;
        // Three-stage pin synchroniser; only stage two feeds stage three
        st_next.sync_a = {st_reg.sync_a[1:0], PIN_IN_A};
        st_next.sync_b = {st_reg.sync_b[1:0], PIN_IN_B};
        // A change counts once the last two stages agree
        if (st_reg.sync_a[1] == st_reg.sync_a[2]) begin
            st_next.pin_a = st_reg.sync_a[2];
        end
        if (st_reg.sync_b[1] == st_reg.sync_b[2]) begin
            st_next.pin_b = st_reg.sync_b[2];
        end
        // Register writes through the base address or an alias
        if (WR) begin
            case (base)
                LGC_OFF_CON: begin
                    st_next.con = lgc_apply(st_reg.con, WDATA, op,
                                            LGC_CON_WMASK);
                end
                LGC_OFF_SEL: begin
                    st_next.sel = lgc_apply(st_reg.sel, WDATA, op,
                                            LGC_SEL_WMASK);
                end
                LGC_OFF_GLS: begin
                    st_next.gls = lgc_apply(st_reg.gls, WDATA, op,
                                            LGC_GLS_WMASK);
                end
                default: begin
                    // Unmapped writes are dropped
                end
            endcase
        end
        // Output after polarity, forced low while the cell is off
        if (cell_on) begin
            st_next.out = fn_out ^ st_reg.con[LGC_OUTINV_BIT];
        end else begin
            st_next.out = 1'b0;
        end
        // Edge pulses; with both enables set each edge still pulses
        st_next.irq = (st_reg.con[LGC_RISE_BIT] & ~st_reg.out &
                       st_next.out) |
                      (st_reg.con[LGC_FALL_BIT] & st_reg.out &
                       ~st_next.out);
        // Read data stand for one cycle only; aliases read the base
        st_next.rdata = LGC_RESET_VAL;
        if (RD) begin
            case (base)
                LGC_OFF_CON: begin
                    st_next.rdata = st_reg.con;
                    st_next.rdata[LGC_STATUS_BIT] = st_reg.out;
                end
                LGC_OFF_SEL: st_next.rdata = st_reg.sel;
                LGC_OFF_GLS: st_next.rdata = st_reg.gls;
                default: st_next.rdata = LGC_RESET_VAL;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign RDATA = st_reg.rdata;
    assign CELL_OUT = st_reg.out;
    assign PIN_OUT = st_reg.out;
    // Disabled cell drops the enable too, so the pin is released
    assign PIN_OUTPUT_ENABLE = st_reg.con[LGC_OE_BIT] & cell_on;
    assign IRQ = st_reg.irq & cell_on;

endmodule

// file: rtl/lgc_fn.sv
// Logic function stage of the configurable logic cell.
`timescale 1ns/1ps
module lgc_fn
    import lgc_pkg::*;
#(
    parameter int CLK_IDX = 0,   // Gate used as clock or latch enable
    parameter int D_IDX = 1,     // Gate used as data
    parameter int RST_IDX = 2,   // Gate used as reset
    parameter int D2_IDX = 3,    // Gate used as second data or K
    parameter int SET_IDX = 3    // Gate used as set
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic [2:0] mode,
    input wire logic [3:0] gate,
    output logic fn_out
);

    // ************************************************************
    // State
    // ************************************************************
    lgc_fn_state_t st_reg;   // Registered state
    lgc_fn_state_t st_next;  // Next state
    logic clk_rise;          // Rising edge of the gate clock
    logic d;
    logic r;
    logic s;
    logic k;

    // Gate routing, sampled on the system clock
    assign d = gate[D_IDX];
    assign r = gate[RST_IDX];
    assign s = gate[SET_IDX];
    assign k = gate[D2_IDX];
    assign clk_rise = gate[CLK_IDX] & ~st_reg.clk_prev;

    // Function select and next stored value
    always_comb begin
        st_next = st_reg;
        st_next.clk_prev = gate[CLK_IDX];
        fn_out = 1'b0;
        case (lgc_mode_t'(mode))
            LGC_AND_OR: begin
                fn_out = (gate[0] & gate[1]) | (gate[2] & gate[3]);
            end
            LGC_OR_XOR: begin
                fn_out = (gate[0] | gate[1]) ^ (gate[2] | gate[3]);
            end
            LGC_AND4: begin
                fn_out = &gate;
            end
            LGC_SR_LATCH: begin
                // Reset dominates when both sides are active
                if (gate[2] | gate[3]) begin
                    st_next.q = 1'b0;
                end else if (gate[0] | gate[1]) begin
                    st_next.q = 1'b1;
                end
                fn_out = st_next.q;
            end
            LGC_DFF_SR: begin
                if (r) begin
                    st_next.q = 1'b0;
                end else if (s) begin
                    st_next.q = 1'b1;
                end else if (clk_rise) begin
                    st_next.q = d;
                end
                fn_out = st_next.q;
            end
            LGC_DFF2_R: begin
                if (r) begin
                    st_next.q = 1'b0;
                end else if (clk_rise) begin
                    st_next.q = d & k;
                end
                fn_out = st_next.q;
            end
            LGC_JK_R: begin
                if (r) begin
                    st_next.q = 1'b0;
                end else if (clk_rise) begin
                    case ({d, k})
                        2'h1: st_next.q = 1'b0;
                        2'h2: st_next.q = 1'b1;
                        2'h3: st_next.q = ~st_reg.q;
                        default: st_next.q = st_reg.q;
                    endcase
                end
                fn_out = st_next.q;
            end
            LGC_LATCH_SR: begin
                if (r) begin
                    st_next.q = 1'b0;
                end else if (s) begin
                    st_next.q = 1'b1;
                end else if (gate[CLK_IDX]) begin
                    st_next.q = d;
                end
                fn_out = st_next.q;
            end
            default: begin
                fn_out = 1'b0;
            end
        endcase
        // A disabled cell holds its stored bit at zero
        if (!enable) begin
            st_next.q = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule

// file: rtl/lgc_pkg.sv
// Shared constants and types of the configurable logic cell.
package lgc_pkg;

    // ************************************************************
    // Register map and bus
    // ************************************************************
    localparam int LGC_ADDR_W = 8;                    // Byte address width
    localparam logic [7:0] LGC_OFF_CON = 8'h00;       // Control register
    localparam logic [7:0] LGC_OFF_SEL = 8'h10;       // Input select register
    localparam logic [7:0] LGC_OFF_GLS = 8'h20;       // Gate enable register
    localparam logic [7:0] LGC_BASE_MASK = 8'hF0;     // Register base bits

    // Alias operation in address bits 3:2
    localparam logic [1:0] LGC_OP_WRITE = 2'h0;
    localparam logic [1:0] LGC_OP_CLR = 2'h1;
    localparam logic [1:0] LGC_OP_SET = 2'h2;
    localparam logic [1:0] LGC_OP_INV = 2'h3;

    // Writable masks; other bits read zero, except control bit 6, which reads the output status
    localparam logic [31:0] LGC_CON_WMASK = 32'h000F_8CA7;
    localparam logic [31:0] LGC_SEL_WMASK = 32'h0000_7777;
    localparam logic [31:0] LGC_GLS_WMASK = 32'hFFFF_FFFF;
    localparam logic [31:0] LGC_RESET_VAL = 32'h0000_0000;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int LGC_MODE_LSB = 0;
    localparam int LGC_OUTINV_BIT = 5;
    localparam int LGC_STATUS_BIT = 6;
    localparam int LGC_OE_BIT = 7;
    localparam int LGC_FALL_BIT = 10;
    localparam int LGC_RISE_BIT = 11;
    localparam int LGC_ON_BIT = 15;
    localparam int LGC_GPOL_LSB = 16;
    localparam int LGC_SEL1_LSB = 0;
    localparam int LGC_SEL2_LSB = 4;
    localparam int LGC_SEL3_LSB = 8;
    localparam int LGC_SEL4_LSB = 12;
    localparam int LGC_GATE_FIELD_W = 8;              // Enables per gate

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        LGC_AND_OR, LGC_OR_XOR, LGC_AND4, LGC_SR_LATCH,
        LGC_DFF_SR, LGC_DFF2_R, LGC_JK_R, LGC_LATCH_SR
    } lgc_mode_t;

    typedef struct packed {
        logic [31:0] con;       // Control register storage
        logic [31:0] sel;       // Selector codes
        logic [31:0] gls;       // Gate source enables
        logic [2:0] sync_a;     // Pin A synchroniser
        logic [2:0] sync_b;     // Pin B synchroniser
        logic pin_a;            // Filtered pin A
        logic pin_b;            // Filtered pin B
        logic out;              // Cell output status
        logic irq;              // Interrupt request pulse
        logic [31:0] rdata;     // Read data
    } lgc_state_t;

    typedef struct packed {
        logic q;                // Stored bit of sequential modes
        logic clk_prev;         // Last value of the gate clock
    } lgc_fn_state_t;

endpackage

// file: test/lgc_cell_sva.sv
// Concurrent checks on the ports of the logic cell.
`timescale 1ns/1ps
module lgc_cell_chk
    import lgc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic [LGC_ADDR_W-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire logic CELL_OUT,
    input wire logic PIN_OUT,
    input wire logic PIN_OUTPUT_ENABLE,
    input wire logic IRQ
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);

    // ************************************************************
    // Shadow of the control register
    // ************************************************************
    logic [31:0] con_reg; // Control bits as software wrote them
    logic [31:0] con_next;
    logic con_wr;
    logic con_rd;
    logic sel_rd;

    assign con_wr = WR && ((ADDR & LGC_BASE_MASK) == LGC_OFF_CON);
    assign con_rd = RD && ((ADDR & LGC_BASE_MASK) == LGC_OFF_CON);
    assign sel_rd = RD && ((ADDR & LGC_BASE_MASK) == LGC_OFF_SEL);

    // Alias writes touch only the bits written as one
    always_comb begin
        con_next = con_reg;
        if (con_wr) begin
            case (ADDR[3:2])
                LGC_OP_CLR: con_next = con_reg & ~WDATA;
                LGC_OP_SET: con_next = con_reg | WDATA;
                LGC_OP_INV: con_next = con_reg ^ WDATA;
                default: con_next = WDATA;
            endcase
        end
    end

    // Shadow follows the same synchronous reset as the cell
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            con_reg <= 32'h0000_0000;
        end else begin
            con_reg <= con_next;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    AST_PIN_FOLLOWS: assert property (PIN_OUT == CELL_OUT)
        else $error("pin output differs from cell output");
    AST_OE_GATED: assert property (
        PIN_OUTPUT_ENABLE == (con_reg[7] && con_reg[15]))
        else $error("pin enable not equal to enable and port bits");
    AST_OFF_ZERO: assert property (!con_reg[15] |=> !CELL_OUT && !IRQ)
        else $error("disabled cell drives an output");
    AST_RISE_IRQ: assert property (
        $rose(CELL_OUT) |-> IRQ == $past(con_reg[11]))
        else $error("rising output edge gave wrong interrupt");
    AST_FALL_IRQ: assert property (
        $fell(CELL_OUT) && $past(con_reg[15]) |-> IRQ == $past(con_reg[10]))
        else $error("falling output edge gave wrong interrupt");
    AST_IRQ_PULSE: assert property (
        IRQ |-> CELL_OUT != $past(CELL_OUT))
        else $error("interrupt without an output edge");
    AST_STATUS_READ: assert property (
        con_rd |=> RDATA[LGC_STATUS_BIT] == $past(CELL_OUT))
        else $error("status bit does not mirror the output");
    AST_CON_RSVD: assert property (
        con_rd |=> (RDATA & 32'hFFF0_7318) == 32'h0000_0000)
        else $error("unused control bits read nonzero");
    AST_SEL_RSVD: assert property (
        sel_rd |=> (RDATA & 32'hFFFF_8888) == 32'h0000_0000)
        else $error("unused selector bits read nonzero");
    AST_UNMAPPED: assert property (
        RD && ADDR[7:4] > 4'h2 |=> RDATA == 32'h0000_0000)
        else $error("unmapped read returned data");
endmodule

bind lgc_cell lgc_cell_chk chk_u (
    .CLK_SYS(CLK_SYS),
    .SRST(SRST),
    .ADDR(ADDR),
    .WDATA(WDATA),
    .WR(WR),
    .RD(RD),
    .RDATA(RDATA),
    .CELL_OUT(CELL_OUT),
    .PIN_OUT(PIN_OUT),
    .PIN_OUTPUT_ENABLE(PIN_OUTPUT_ENABLE),
    .IRQ(IRQ)
);

// file: test/lgc_cell_tb_top.sv
// Self-checking bench of the logic cell with its source model.
`timescale 1ns/1ps
module lgc_cell_tb_top;
    import lgc_pkg::*;
    localparam logic [31:0] ON_OE = 32'h0000_8080;
    localparam logic [31:0] SEL_CFG = 32'h0000_1211; // Codes 1,1,2,1
    localparam logic [31:0] GLS_CFG = 32'h8020_0802; // Gate g = source g
    // Sequential steps: mode, gate pattern, expected output
    localparam logic [11:0] SEQ [35] = '{
        12'h311, 12'h301, 12'h340, 12'h350, 12'h300,
        12'h440, 12'h420, 12'h431, 12'h401, 12'h481, 12'h440, 12'h4C0,
        12'h481, 12'h540, 12'h5A0, 12'h5B1, 12'h501, 12'h530,
        12'h640, 12'h600, 12'h631, 12'h601, 12'h6B0, 12'h600, 12'h6B1,
        12'h601, 12'h690, 12'h740, 12'h731, 12'h710, 12'h731, 12'h721,
        12'h701, 12'h781, 12'h740};
    // Register table: address, write value, read-back value
    localparam logic [7:0] RA [7] = '{8'h00, 8'h10, 8'h10, 8'h18, 8'h14,
        8'h1C, 8'h30};
    // Control write leaves out bit 10 so both edge enables never meet
    localparam logic [31:0] RW [7] = '{32'hFFFF_7BFF, 32'hFFFF_FFFF,
        32'h0000_5555, 32'h0000_2222, 32'h0000_0101, 32'h0000_0011,
        32'hFFFF_FFFF};
    localparam logic [31:0] RE [7] = '{32'h000F_08A7, 32'h0000_7777,
        32'h0000_5555, 32'h0000_7777, 32'h0000_7676, 32'h0000_7667,
        32'h0000_0000};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] pat = 4'h0;
    logic [31:0] rdata;
    logic cell_out, pin_out, pin_oe, irq, pin_a, pin_b, cmp2, sib, busy;
    logic [7:1] s1, s2;
    logic [31:0] d;
    int irq_cnt, c0;
    int failures = 0;
    int total_checks = 0;

    always #20 clk = ~clk;

    lgc_src_model model_u (.clk(clk), .srst(srst), .pat(pat), .irq(irq),
        .pin_a(pin_a), .pin_b(pin_b), .sel1_src(s1), .sel2_src(s2),
        .cmp2(cmp2), .sibling(sib), .busy_src(busy), .irq_count(irq_cnt));

    lgc_cell dut_u (.CLK_SYS(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .PIN_IN_A(pin_a), .PIN_IN_B(pin_b),
        .SEL1_SRC(s1), .SEL2_SRC(s2), .CMP2_OUT(cmp2), .SPI_SDO(busy),
        .UART_RX(busy), .CAPTURE2_OUTPUT(busy), .CAPTURE2_MATCH(busy),
        .CAPTURE3_MATCH(busy), .SIBLING_OUT(sib), .CAPTURE3_OUTPUT(busy),
        .SPI_SDI(busy), .CLOCK_CALENDAR_EVENT(busy),
        .MULTI_CAPTURE1_MATCH(busy), .CELL_OUT(cell_out), .PIN_OUT(pin_out),
        .PIN_OUTPUT_ENABLE(pin_oe), .IRQ(irq));

    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    // Entered just after an edge; a gap cycle keeps strobes clean
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask

    // Configure, drive gates, then look at the cell, pin and pin enable outputs and the status bit once settled
    task automatic step(input logic [31:0] con, input logic [3:0] p,
        input logic e);
        logic [31:0] v;
        reg_wr(LGC_OFF_CON, con);
        pat <= p;
        repeat (4) @(posedge clk);
        #1 check_val({31'h0, cell_out}, {31'h0, e});
        check_val({31'h0, pin_out}, {31'h0, e});
        check_val({31'h0, pin_oe}, {31'h0, con[7] & con[15]});
        @(posedge clk);
        reg_rd(LGC_OFF_CON, v);
        check_val({31'h0, v[LGC_STATUS_BIT]}, {31'h0, e});
    endtask

    function automatic logic comb_exp(input int m, input logic [3:0] g);
        case (m)
            0: return (g[0] & g[1]) | (g[2] & g[3]);
            1: return (g[0] | g[1]) ^ (g[2] | g[3]);
            default: return &g;
        endcase
    endfunction

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        print_verdict();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            reg_rd(8'(16 * i), d);
            check_val(d, 32'h0000_0000);
        end
        // Masks, aliases and an unmapped place
        for (int i = 0; i < 7; i++) begin
            reg_wr(RA[i], RW[i]);
            reg_rd(RA[i], d);
            check_val(d, RE[i]);
        end
        reg_wr(LGC_OFF_SEL, SEL_CFG);
        reg_wr(LGC_OFF_GLS, GLS_CFG);
        for (int m = 0; m < 3; m++) begin
            for (int p = 0; p < 16; p++) begin
                step(ON_OE | 32'(m), 4'(p), comb_exp(m, 4'(p)));
            end
        end
        foreach (SEQ[i]) begin
            step(ON_OE | 32'(SEQ[i][11:8]), SEQ[i][7:4], SEQ[i][0]);
        end
        for (int g = 0; g < 4; g++) begin
            step(ON_OE | 32'h2 | (32'h1 << (16 + g)),
                4'hF ^ (4'h1 << g), 1'b1);
        end
        step(ON_OE | 32'h22, 4'hF, 1'b0);
        step(ON_OE | 32'h22, 4'h0, 1'b1);
        step(32'h0000_0082, 4'hF, 1'b0);
        reg_wr(LGC_OFF_GLS, 32'h4010_0401);
        step(ON_OE | 32'h2, 4'h0, 1'b1);
        reg_wr(LGC_OFF_GLS, 32'h8020_080A);
        step(ON_OE | 32'h2, 4'hE, 1'b1);
        reg_wr(LGC_OFF_GLS, GLS_CFG);
        reg_wr(LGC_OFF_SEL, 32'h0000_4211);
        step(ON_OE | 32'h2, 4'hF, 1'b0);
        // Pins settle through the filter before the step looks
        pat <= 4'h6;
        reg_wr(LGC_OFF_SEL, 32'h0000_0210);
        step(ON_OE | 32'h2, 4'h6, 1'b1);
        reg_wr(LGC_OFF_SEL, SEL_CFG);
        // Edge interrupts, never both enables at once
        step(ON_OE | 32'h802, 4'h0, 1'b0);
        c0 = irq_cnt;
        step(ON_OE | 32'h802, 4'hF, 1'b1);
        check_val(32'(irq_cnt), 32'(c0 + 1));
        step(ON_OE | 32'h802, 4'h0, 1'b0);
        check_val(32'(irq_cnt), 32'(c0 + 1));
        step(ON_OE | 32'h402, 4'hF, 1'b1);
        check_val(32'(irq_cnt), 32'(c0 + 1));
        step(ON_OE | 32'h402, 4'h0, 1'b0);
        check_val(32'(irq_cnt), 32'(c0 + 2));
        print_verdict();
    end
endmodule

// file: test/lgc_src_model.sv
// Model of the sources, pins and interrupt sink around the cell.
`timescale 1ns/1ps
module lgc_src_model
    import lgc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] pat,
    input wire logic irq,
    output logic pin_a,
    output logic pin_b,
    output logic [7:1] sel1_src,
    output logic [7:1] sel2_src,
    output logic cmp2,
    output logic sibling,
    output logic busy_src,
    output int irq_count
);
    logic tog_reg; // Unselected sources wiggle so a wrong pick shows

    // Toggle source and interrupt pulse counter
    always_ff @(posedge clk) begin
        if (srst) begin
            tog_reg <= 1'b0;
            irq_count <= 0;
        end else begin
            tog_reg <= ~tog_reg;
            if (irq) begin
                irq_count <= irq_count + 1;
            end
        end
    end

    // Selected sources carry the bench pattern, gate order 1..4
    assign sel1_src = {{6{tog_reg}}, pat[0]};
    assign sel2_src = {{6{tog_reg}}, pat[1]};
    assign cmp2 = pat[2];
    assign sibling = pat[3];
    // Pins carry inverted gate bits, steady so the pin filter passes them
    assign pin_a = ~pat[0];
    assign pin_b = ~pat[3];
    assign busy_src = tog_reg;
endmodule
